// ==== src/trig_ctrl_pkg.sv ====
/*
  Package for the storage trigger controller: register map, field
  positions, reset values, timing constants and shared types.
  Assumes a 100 MHz system clock and a 32-bit classic Wishbone bus.
*/
package trig_ctrl_pkg;

  // Clock and tick timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_PERIOD_S   = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
  localparam int unsigned POST_MARGIN_MIN = 5;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_FOLLOW    = 8'h04;
  localparam logic [7:0] ADDR_POSTPROC  = 8'h08;
  localparam logic [7:0] ADDR_PRETRIG   = 8'h0c;
  localparam logic [7:0] ADDR_POSTTRIG  = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;
  localparam logic [7:0] ADDR_WORD      = 8'h18;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_START_DEF = 2;
  localparam int unsigned CTRL_STOP_DEF  = 3;
  localparam int unsigned CTRL_SAVE_TRIG = 4;
  localparam int unsigned CTRL_CONT      = 5;
  localparam int unsigned CTRL_ENABLE    = 6;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  // Trigger status word bit positions
  localparam int unsigned SB_PRE     = 0;
  localparam int unsigned SB_BETWEEN = 1;
  localparam int unsigned SB_POST    = 2;
  localparam int unsigned SB_EVENT   = 3;
  localparam int unsigned SB_MANEUV  = 4;
  localparam int unsigned SB_WAKEUP  = 12;
  localparam int unsigned SB_PWRBAD  = 13;
  localparam int unsigned SB_PWRGOOD = 14;
  localparam int unsigned SB_IGN     = 15;

  // Interrupt event bits
  localparam int unsigned IRQ_STORE_ON  = 0;
  localparam int unsigned IRQ_STORE_OFF = 1;
  localparam int unsigned IRQ_SHUTDOWN  = 2;
  localparam int unsigned IRQ_WIDTH     = 3;

  // Trigger modes
  typedef enum logic [1:0] {
    MODE_START    = 2'b00,
    MODE_STOP     = 2'b01,
    MODE_STARTSTP = 2'b10,
    MODE_LEVEL    = 2'b11
  } trig_mode_e;

  // Storage state machine, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_STORE   = 3'b001,
    ST_FOLLOW  = 3'b011,
    ST_POSTPRC = 3'b010,
    ST_OFF     = 3'b110
  } store_state_e;

  // Inputs from condition evaluator, remote line and power management
  typedef struct packed {
    logic start_pulse;
    logic stop_pulse;
    logic cond_level;
    logic remote_off;
    logic power_down;
    logic sample_strobe;
  } trig_in_s;

  typedef struct packed {
    logic bus_activity_wakeup;
    logic ignition_remote_line;
    logic power_bad;
    logic power_good;
    logic maneuver;
  } sys_flags_s;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wb_req_s;

endpackage : trig_ctrl_pkg

// ==== src/storage_trigger_control.sv ====
/*
  Storage trigger controller: decides when samples are stored under four
  trigger modes, runs the follow-up and post-processing timeouts and
  builds the 16-bit trigger status word. Registers over classic Wishbone.
  Assumes trigger inputs are synchronous to i_clk_sys and that the
  ignition remote line arrives already debounced.
*/
// Function
// - Start mode stores from the start pulse until orderly power-down.
// - Nonzero follow-up time extends storing by that many seconds.
// - Stop mode stores from power-up until the trigger pulse.
// - Stop mode without event records until remote-off or follow-up expiry.
// - Start-and-stop mode stores between start pulse and stop pulse.
// - Without stop event, recording runs until remote-off or follow-up expiry.
// - Level mode stores while the condition holds, one cycle behind it.
// - Level held true records until remote-off or follow-up expiry.
// - After remote-off, shut down when post-processing timeout elapses.
// - With trigger saving on, a 16-bit status word accompanies each sample.
// - Bit 0 marks pre-trigger time, bit 2 post-trigger time.
// - Bit 1 marks storing; held set throughout continuous acquisition.
// - Bit 3 pulses one sample per rising trigger, two if the edge meets a strobe; once in continuous.
// - Bit 4 marks maneuver recording running.
// - Bits 12, 13, 14 show wake-up, supply lost, capacitors charged.
// - Bit 15 carries the debounced ignition remote line.
`timescale 1ns/1ps

module storage_trigger_control
  import trig_ctrl_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYCLES
)
(
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_reset,
  input  wire trig_ctrl_pkg::wb_req_s      i_wb,
  output logic                             o_wb_ack,
  output logic [31:0]                      o_wb_dat,
  input  wire trig_ctrl_pkg::trig_in_s     i_trig,
  input  wire trig_ctrl_pkg::sys_flags_s   i_flags,
  output logic                             o_storing,
  output logic                             o_shutdown,
  output logic [15:0]                      o_status_word,
  output logic                             o_status_valid,
  output logic                             o_irq
);
  import trig_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]      ctrl_reg;
  logic [15:0]      follow_reg;
  logic [15:0]      postproc_reg;
  logic [15:0]      pretrig_reg;
  logic [15:0]      posttrig_reg;
  logic [IRQ_WIDTH-1:0] irq_stat_reg;
  logic [IRQ_WIDTH-1:0] irq_mask_reg;
  store_state_e     state_reg;
  store_state_e     state_next;
  logic [31:0]      tick_cnt_reg;
  logic [15:0]      follow_cnt_reg;
  logic [15:0]      post_cnt_reg;
  logic [15:0]      pre_cnt_reg;
  logic [15:0]      ptrig_cnt_reg;
  logic             cond_prev_reg;
  logic             cont_event_done_reg;
  logic             ack_reg;
  logic [31:0]      rdat_reg;
  logic [15:0]      word_reg;
  logic             word_valid_reg;
  logic             irq_reg;
  logic             event_pend_reg;
  logic             stop_seen_reg;
  logic             post_run_reg;

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  wire trig_mode_e mode       = trig_mode_e'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  wire logic       start_def  = ctrl_reg[CTRL_START_DEF];
  wire logic       stop_def   = ctrl_reg[CTRL_STOP_DEF];
  wire logic       save_trig  = ctrl_reg[CTRL_SAVE_TRIG];
  wire logic       cont_mode  = ctrl_reg[CTRL_CONT];
  wire logic       enable     = ctrl_reg[CTRL_ENABLE];
  wire logic       tick       = (tick_cnt_reg == TICK_CYC - 1);

  // Saturating decrement used by all second counters
  function automatic logic [15:0] dec_sat(input logic [15:0] v);
    dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction : dec_sat

  ////////////////////////////////////////////////////////////////////////
  // Start and end conditions per mode
  wire logic rise       = i_trig.cond_level & ~cond_prev_reg;
  wire logic start_hit  =
    (mode == MODE_START)    ? i_trig.start_pulse :
    (mode == MODE_STOP)     ? ~stop_seen_reg :
    (mode == MODE_STARTSTP) ? i_trig.start_pulse :
                              i_trig.cond_level;
  wire logic stop_hit   =
    (mode == MODE_START)    ? i_trig.power_down :
    (mode == MODE_STOP)     ? (start_def & i_trig.start_pulse) :
    (mode == MODE_STARTSTP) ? (stop_def & i_trig.stop_pulse) :
                              ~i_trig.cond_level;
  wire logic end_hit    = stop_hit | i_trig.remote_off;
  wire logic follow_on  = (follow_reg != 16'h0000);

  ////////////////////////////////////////////////////////////////////////
  // State transitions
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (i_trig.remote_off & enable)
          state_next = ST_POSTPRC;
        else if (enable & start_hit)
          state_next = ST_STORE;
      end
      ST_STORE:
      begin
        if (i_trig.remote_off & ~follow_on)
          state_next = ST_POSTPRC;
        else if (end_hit)
          state_next = follow_on ? ST_FOLLOW : ST_IDLE;
      end
      ST_FOLLOW:
      begin
        if (follow_cnt_reg == 16'h0000)
          state_next = i_trig.remote_off ? ST_POSTPRC : ST_IDLE;
        else if ((mode == MODE_LEVEL) & i_trig.cond_level & ~i_trig.remote_off)
          state_next = ST_STORE;
      end
      ST_POSTPRC:
      begin
        if (post_cnt_reg == 16'h0000)
          state_next = ST_OFF;
      end
      ST_OFF:
        state_next = ST_OFF;
      default:
        state_next = ST_IDLE;
    endcase
    // Timeout after remote-off cuts any state, follow-up included
    if (post_run_reg & (post_cnt_reg == 16'h0000) & (state_reg != ST_OFF))
      state_next = ST_OFF;
  end

  // State register and second tick
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state_reg     <= ST_IDLE;
      tick_cnt_reg  <= 32'h0000_0000;
      stop_seen_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      // Stop mode stores once per power-up, no restart after the trigger
      stop_seen_reg <= stop_seen_reg | ((mode == MODE_STOP) & stop_hit);
      tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Follow-up, post-processing, pre- and post-trigger counters
  wire logic enter_follow = (state_reg != ST_FOLLOW) & (state_next == ST_FOLLOW);
  wire logic post_go      = i_trig.remote_off & enable & ~post_run_reg & (state_reg != ST_OFF);
  wire logic enter_store  = (state_reg != ST_STORE) & (state_next == ST_STORE);

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      follow_cnt_reg <= 16'h0000;
      post_cnt_reg   <= 16'h0000;
      pre_cnt_reg    <= 16'h0000;
      ptrig_cnt_reg  <= 16'h0000;
      post_run_reg   <= 1'b0;
    end
    else
    begin
      if (post_go)
        post_run_reg <= 1'b1;
      if (enter_follow)
        follow_cnt_reg <= follow_reg;
      else if (tick)
        follow_cnt_reg <= dec_sat(follow_cnt_reg);
      if (post_go)
        post_cnt_reg <= postproc_reg;
      else if (tick)
        post_cnt_reg <= dec_sat(post_cnt_reg);
      if (enter_store)
        pre_cnt_reg <= pretrig_reg;
      else if (tick)
        pre_cnt_reg <= dec_sat(pre_cnt_reg);
      if (enter_follow)
        ptrig_cnt_reg <= posttrig_reg;
      else if (tick)
        ptrig_cnt_reg <= dec_sat(ptrig_cnt_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Trigger status word assembly
  wire logic storing_now = (state_reg == ST_STORE) | (state_reg == ST_FOLLOW);
  wire logic event_bit   = cont_mode ? (~cont_event_done_reg & storing_now)
                                     : (rise | event_pend_reg);
  wire logic [15:0] word_next = {
    i_flags.ignition_remote_line,
    i_flags.power_good,
    i_flags.power_bad,
    i_flags.bus_activity_wakeup,
    7'h00,
    i_flags.maneuver,
    event_bit,
    (state_reg == ST_FOLLOW) & (ptrig_cnt_reg != 16'h0000),
    cont_mode ? storing_now : (state_reg == ST_STORE),
    (state_reg == ST_STORE) & (pre_cnt_reg != 16'h0000)
  };

  // Word latched on each sample; rising edge held until the first strobe after its cycle
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      cond_prev_reg       <= 1'b0;
      event_pend_reg      <= 1'b0;
      cont_event_done_reg <= 1'b0;
      word_reg            <= 16'h0000;
      word_valid_reg      <= 1'b0;
    end
    else
    begin
      cond_prev_reg  <= i_trig.cond_level;
      word_valid_reg <= i_trig.sample_strobe & save_trig & storing_now;
      if (i_trig.sample_strobe)
        word_reg <= word_next;
      if (rise)
        event_pend_reg <= 1'b1;
      else if (i_trig.sample_strobe)
        event_pend_reg <= 1'b0;
      if (~storing_now)
        cont_event_done_reg <= 1'b0;
      else if (i_trig.sample_strobe)
        cont_event_done_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave decode
  wire logic        wb_hit   = i_wb.cyc & i_wb.stb & ~ack_reg;
  wire logic        wb_wr    = wb_hit & i_wb.we & (&i_wb.sel);
  wire logic [IRQ_WIDTH-1:0] irq_events = {
    (state_next == ST_OFF) & (state_reg != ST_OFF),
    storing_now & ~(state_next == ST_STORE | state_next == ST_FOLLOW),
    enter_store & (state_reg == ST_IDLE)
  };
  wire logic [31:0] rd_mux =
    (i_wb.adr == ADDR_CTRL)     ? ctrl_reg :
    (i_wb.adr == ADDR_FOLLOW)   ? {16'h0000, follow_reg} :
    (i_wb.adr == ADDR_POSTPROC) ? {16'h0000, postproc_reg} :
    (i_wb.adr == ADDR_PRETRIG)  ? {16'h0000, pretrig_reg} :
    (i_wb.adr == ADDR_POSTTRIG) ? {16'h0000, posttrig_reg} :
    (i_wb.adr == ADDR_STATUS)   ? {16'h0000, follow_cnt_reg[12:0], state_reg} :
    (i_wb.adr == ADDR_WORD)     ? {16'h0000, word_reg} :
    (i_wb.adr == ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
    (i_wb.adr == ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
                                  32'h0000_0000;

  // Configuration registers; writes need all four byte lanes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      ctrl_reg     <= CTRL_RESET;
      follow_reg   <= 16'h0000;
      postproc_reg <= 16'h0000;
      pretrig_reg  <= 16'h0000;
      posttrig_reg <= 16'h0000;
      irq_mask_reg <= '0;
    end
    else if (wb_wr)
    begin
      if (i_wb.adr == ADDR_CTRL)
        ctrl_reg <= {25'h0, i_wb.dat[6:0]};
      if (i_wb.adr == ADDR_FOLLOW)
        follow_reg <= i_wb.dat[15:0];
      if (i_wb.adr == ADDR_POSTPROC)
        postproc_reg <= i_wb.dat[15:0];
      if (i_wb.adr == ADDR_PRETRIG)
        pretrig_reg <= i_wb.dat[15:0];
      if (i_wb.adr == ADDR_POSTTRIG)
        posttrig_reg <= i_wb.dat[15:0];
      if (i_wb.adr == ADDR_IRQ_MASK)
        irq_mask_reg <= i_wb.dat[IRQ_WIDTH-1:0];
    end
  end

  // Sticky interrupt status; a new event wins over write-one-to-clear
  wire logic [IRQ_WIDTH-1:0] irq_clr =
    (wb_wr & (i_wb.adr == ADDR_IRQ_STAT)) ? i_wb.dat[IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
      ack_reg      <= 1'b0;
      rdat_reg     <= 32'h0000_0000;
    end
    else
    begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_events;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
      ack_reg      <= wb_hit;
      rdat_reg     <= wb_hit ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs
  logic storing_reg;
  logic shutdown_reg;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      storing_reg  <= 1'b0;
      shutdown_reg <= 1'b0;
    end
    else
    begin
      storing_reg  <= (state_next == ST_STORE) | (state_next == ST_FOLLOW);
      shutdown_reg <= (state_next == ST_OFF);
    end
  end

  assign o_wb_ack       = ack_reg;
  assign o_wb_dat       = rdat_reg;
  assign o_storing      = storing_reg;
  assign o_shutdown     = shutdown_reg;
  assign o_status_word  = word_reg;
  assign o_status_valid = word_valid_reg;
  assign o_irq          = irq_reg;

endmodule : storage_trigger_control

// ==== sim/trig_source_model.sv ====
/*
  Far-side model: trigger evaluator, remote line and power management.
  Assumes bench requests change by non-blocking assignment on i_clk_sys.
*/
`timescale 1ns/1ps

module trig_source_model
  import trig_ctrl_pkg::*;
(
  input  wire logic                      i_clk_sys,
  input  wire trig_ctrl_pkg::trig_in_s   i_req,
  input  wire trig_ctrl_pkg::sys_flags_s i_raw,
  output trig_ctrl_pkg::trig_in_s        o_trig  = '0,
  output trig_ctrl_pkg::sys_flags_s      o_flags = '0
);
  // Evaluator output stage; pulses last one cycle, levels are held
  always @(posedge i_clk_sys)
  begin
    o_trig  <= i_req;
    o_flags <= i_raw;
  end
endmodule : trig_source_model

// ==== sim/storage_trigger_control_asserts.sv ====
/*
  Port checker for the storage trigger controller.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps

module storage_trigger_control_asserts
  import trig_ctrl_pkg::*;
#(
  parameter int unsigned TICK_CYC = 10
)
(
  input wire logic                       i_clk_sys,
  input wire logic                       i_reset,
  input wire trig_ctrl_pkg::wb_req_s     i_wb,
  input wire logic                       o_wb_ack,
  input wire logic [31:0]                o_wb_dat,
  input wire trig_ctrl_pkg::trig_in_s    i_trig,
  input wire trig_ctrl_pkg::sys_flags_s  i_flags,
  input wire logic                       o_storing,
  input wire logic                       o_shutdown,
  input wire logic [15:0]                o_status_word,
  input wire logic                       o_status_valid,
  input wire logic                       o_irq
);
  logic [6:0]  ctrl_reg;
  logic [15:0] follow_reg;
  logic        ended_reg;

  // Decode of accepted writes and of ending events
  wire       wr_ok = i_wb.cyc && i_wb.stb && i_wb.we && !o_wb_ack && i_wb.sel == 4'hf;
  wire       en    = ctrl_reg[CTRL_ENABLE];
  wire [1:0] md    = ctrl_reg[1:0];
  wire       f0    = follow_reg == 16'h0;
  wire       fok   = follow_reg >= 16'h2 && follow_reg * TICK_CYC < 900;
  wire       fin   = i_trig.power_down || i_trig.remote_off ||
                     (md == 2'h1 && ctrl_reg[CTRL_START_DEF] && i_trig.start_pulse);
  wire       quiet = en && !ended_reg && !fin;

  // Shadow of control and follow-up registers
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      ctrl_reg   <= 7'h0;
      follow_reg <= 16'h0;
      ended_reg  <= 1'b0;
    end
    else
    begin
      if (wr_ok && i_wb.adr == ADDR_CTRL)
        ctrl_reg <= i_wb.dat[6:0];
      if (wr_ok && i_wb.adr == ADDR_FOLLOW)
        follow_reg <= i_wb.dat[15:0];
      if (fin)
        ended_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  property p_wb_ack;
    i_wb.cyc && i_wb.stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("bus ack late or long");
  property p_start_go;
    quiet && md == 2'h0 && i_trig.start_pulse |=> o_storing;
  endproperty
  a_start_go: assert property (p_start_go) else $error("start pulse ignored");
  property p_pd_end;
    en && md == 2'h0 && f0 && o_storing && i_trig.power_down |=> !o_storing;
  endproperty
  a_pd_end: assert property (p_pd_end) else $error("power-down kept storing");
  property p_follow;
    en && md == 2'h0 && fok && o_storing && fin && !ended_reg |=>
      o_storing [*8] ##[1:1000] !o_storing;
  endproperty
  a_follow: assert property (p_follow) else $error("follow-up span wrong");
  property p_stop_run;
    quiet && md == 2'h1 |=> o_storing;
  endproperty
  a_stop_run: assert property (p_stop_run) else $error("stop mode not storing");
  property p_level;
    quiet && md == 2'h3 && f0 |=> o_storing == $past(i_trig.cond_level);
  endproperty
  a_level: assert property (p_level) else $error("level mode mismatch");
  property p_shut;
    o_shutdown |=> o_shutdown && !o_storing;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown not final");
  property p_word;
    i_trig.sample_strobe |=> o_status_word[15:4] == {$past(i_flags.ignition_remote_line),
      $past(i_flags.power_good), $past(i_flags.power_bad),
      $past(i_flags.bus_activity_wakeup), 7'h0, $past(i_flags.maneuver)};
  endproperty
  a_word: assert property (p_word) else $error("status word flags wrong");
  property p_valid_go;
    i_trig.sample_strobe && o_storing && ctrl_reg[CTRL_SAVE_TRIG] && !ended_reg
      |=> o_status_valid;
  endproperty
  a_valid_go: assert property (p_valid_go) else $error("status word missing");
endmodule : storage_trigger_control_asserts

bind storage_trigger_control storage_trigger_control_asserts #(.TICK_CYC(TICK_CYC)) i_chk (
  .i_clk_sys, .i_reset, .i_wb, .o_wb_ack, .o_wb_dat, .i_trig, .i_flags, .o_storing,
  .o_shutdown, .o_status_word, .o_status_valid, .o_irq);

// ==== sim/storage_trigger_control_tb.sv ====
/*
  Self-checking bench for the storage trigger controller.
  Assumes a 100 MHz clock and a one-second tick scaled to TICK cycles.
*/
`timescale 1ns/1ps

module storage_trigger_control_tb;
  import trig_ctrl_pkg::*;
  localparam int unsigned TICK = 10;
  localparam int P_START = 5;
  localparam int P_STOP  = 4;
  localparam int P_PD    = 1;
  logic        i_clk_sys = 1'b0;
  logic        i_reset   = 1'b1;
  wb_req_s     wb        = '0;
  trig_in_s    req       = '0;
  sys_flags_s  raw       = '0;
  trig_in_s    trig;
  sys_flags_s  flags;
  logic        ack, irq, storing, shutdown, sv;
  logic [31:0] rdat;
  logic [15:0] sw;
  logic [32:0] rd_q[$];
  logic [31:0] sw_q[$];
  int          errors   = 0;
  int          compares = 0;
  int          seed     = 65638;
  int          n;

  // 100 MHz clock
  always #5 i_clk_sys = ~i_clk_sys;

  storage_trigger_control #(.TICK_CYC(TICK)) i_dut (
    .i_clk_sys, .i_reset, .i_wb(wb), .o_wb_ack(ack), .o_wb_dat(rdat), .i_trig(trig),
    .i_flags(flags), .o_storing(storing), .o_shutdown(shutdown), .o_status_word(sw),
    .o_status_valid(sv), .o_irq(irq));
  trig_source_model i_src (.i_clk_sys, .i_req(req), .i_raw(raw), .o_trig(trig),
    .o_flags(flags));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got,
                     input logic [31:0] mask = 32'hffff_ffff);
    compares++;
    if ((got & mask) !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got & mask);
    end
  endtask : chk

  task automatic flag(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask : flag

  task automatic results;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // One classic bus cycle; the expected read value is noted first
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel = 4'hf, input logic [31:0] exp = 32'h0);
    int k = 0;
    @(posedge i_clk_sys);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    rd_q.push_back({!we, exp});
    do
    begin
      @(posedge i_clk_sys);
      k++;
    end
    while (!ack && k < 50);
    if (k == 50)
      errors++;
    wb <= '0;
  endtask : bus

  // Random flags, then one sample strobe; on marks a word due, low is bits 3..0
  task automatic sample(input logic on, input logic [3:0] low = 4'h2);
    @(posedge i_clk_sys);
    raw <= 5'($random(seed));
    @(posedge i_clk_sys);
    req.sample_strobe <= 1'b1;
    if (on)
      sw_q.push_back({16'hffff, raw.ignition_remote_line, raw.power_good, raw.power_bad,
                      raw.bus_activity_wakeup, 7'h0, raw.maneuver, low});
    @(posedge i_clk_sys);
    req.sample_strobe <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask : sample

  task automatic pulse(input int which);
    @(posedge i_clk_sys);
    req[which] <= 1'b1;
    @(posedge i_clk_sys);
    req[which] <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask : pulse

  task automatic rst(input int cyc);
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    req     <= '0;
    repeat (cyc) @(posedge i_clk_sys);
    i_reset <= 1'b0;
  endtask : rst

  // Result monitor: oldest note against each answer
  always @(posedge i_clk_sys)
  begin
    logic [32:0] note;
    logic [31:0] wn;
    if (ack && rd_q.size() > 0)
    begin
      note = rd_q.pop_front();
      if (note[32])
        chk("read data", note[31:0], rdat);
    end
    if (sv && sw_q.size() > 0)
    begin
      wn = sw_q.pop_front();
      chk("status word", {16'h0, wn[15:0]}, {16'h0, sw}, {16'h0, wn[31:16]});
    end
    else if (sv)
      flag("status valid", 1'b0, sv);
  end

  // Hang guard well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    results();
  end

  initial
  begin
    rst(12);
    bus(0, ADDR_CTRL, 32'h0, 4'hf, CTRL_RESET);
    bus(1, ADDR_FOLLOW, 32'h5, 4'h3);
    bus(0, ADDR_FOLLOW, 32'h0);
    bus(1, 8'h30, 32'h7);
    bus(0, 8'h30, 32'h0);
    bus(1, ADDR_IRQ_MASK, 32'h7);
    bus(0, ADDR_IRQ_MASK, 32'h0, 4'hf, 32'h7);
    $display("test registers done");
    // Start mode, continuous: saved words, interrupt raise, mask and clear
    bus(1, ADDR_CTRL, 32'h70);
    sample(0);
    pulse(P_START);
    flag("storing", 1'b1, storing);
    sample(1, 4'ha);
    repeat (3) sample(1);
    flag("irq", 1'b1, irq);
    bus(0, ADDR_IRQ_STAT, 32'h0, 4'hf, 32'h1);
    bus(1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge i_clk_sys);
    flag("irq masked", 1'b0, irq);
    bus(1, ADDR_IRQ_MASK, 32'h7);
    bus(1, ADDR_IRQ_STAT, 32'h1);
    repeat (2) @(posedge i_clk_sys);
    flag("irq cleared", 1'b0, irq);
    pulse(P_PD);
    flag("storing", 1'b0, storing);
    sample(0);
    $display("test start mode done");
    rst(2);
    bus(1, ADDR_CTRL, 32'h41);
    repeat (2) @(posedge i_clk_sys);
    flag("storing", 1'b1, storing);
    pulse(P_START);
    flag("storing", 1'b1, storing);
    bus(1, ADDR_CTRL, 32'h45);
    pulse(P_START);
    flag("storing", 1'b0, storing);
    $display("test stop mode done");
    rst(2);
    bus(1, ADDR_CTRL, 32'h42);
    pulse(P_START);
    flag("storing", 1'b1, storing);
    pulse(P_STOP);
    flag("storing", 1'b1, storing);
    bus(1, ADDR_CTRL, 32'h4a);
    pulse(P_STOP);
    flag("storing", 1'b0, storing);
    $display("test start-stop mode done");
    rst(2);
    bus(1, ADDR_CTRL, 32'h43);
    for (n = 0; n < 8; n++)
    begin
      @(posedge i_clk_sys);
      req.cond_level <= 1'($random(seed));
      repeat (3) @(posedge i_clk_sys);
      flag("storing", req.cond_level, storing);
    end
    $display("test level mode done");
    // Remote-off: timeout span from remote-off, follow-up inside it
    rst(2);
    bus(1, ADDR_FOLLOW, 32'h3);
    bus(1, ADDR_POSTPROC, 32'h12f);
    bus(1, ADDR_CTRL, 32'h40);
    pulse(P_START);
    @(posedge i_clk_sys);
    req.remote_off <= 1'b1;
    for (n = 0; storing && n < 100; n++)
      @(posedge i_clk_sys);
    flag("follow span", 1'b1, n >= 2 * TICK && n <= 3 * TICK + 5);
    for (; !shutdown && n < 4000; n++)
      @(posedge i_clk_sys);
    flag("post span", 1'b1, n >= 302 * TICK && n <= 303 * TICK + 5);
    bus(0, ADDR_IRQ_STAT, 32'h0, 4'hf, 32'h7);
    $display("test remote-off done");
    results();
  end
endmodule : storage_trigger_control_tb
